// file: core/fc_dram_pkg.sv
package fc_dram_pkg;

  // ----------------------------------------------------------------
  // command pin encoding (chip select low, function pin selects)
  // ----------------------------------------------------------------
  localparam logic FN_FIRST_RD = 1'h1;  // first: read_activate_cmd
  localparam logic FN_FIRST_WR = 1'h0;  // first: write_activate_cmd
  localparam logic FN_SECOND_LAL = 1'h1;  // second: lower_address_latch_cmd
  localparam logic FN_SECOND_ALT = 1'h0;  // second: mode set after read, refresh after write

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam logic [1:0] BANK_REGULAR = 2'h0;
  localparam logic [1:0] BANK_EXTENDED = 2'h1;
  localparam int LAT_MSB = 6;
  localparam int LAT_LSB = 4;
  localparam int BURST_BIT = 0;
  localparam int STROBE_FREE_BIT = 5;
  localparam int DLL_OFF_BIT = 0;
  localparam logic [2:0] LAT_RESET = 3'h4;
  localparam logic BURST4_RESET = 1'h1;
  localparam logic STROBE_FREE_RESET = 1'h0;

  // ----------------------------------------------------------------
  // timing counts, link clock cycles
  // ----------------------------------------------------------------
  localparam int CW = 8;
  localparam logic [CW-1:0] RECHARGE_CYCLE_TIME = 8'h13;  // 19 cycles at latency four
  localparam logic [CW-1:0] MODE_SET_CYCLE_TIME = 8'h04;
  localparam logic [CW-1:0] POWER_DOWN_EXIT_TO_COMMAND = 8'h03;
  localparam logic [CW-1:0] DLL_SETTLE_TIME = 8'h20;
  localparam logic [CW-1:0] SELFREF_ENTRY_WINDOW_MIN = 8'h01;
  localparam logic [CW-1:0] SELFREF_ENTRY_WINDOW_MAX = 8'h03;
  localparam logic [CW-1:0] POWERDOWN_DECISION_LIMIT = 8'h06;

  // ----------------------------------------------------------------
  // device states
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    ST_IDLE   = 11'h001,
    ST_ACT_RD = 11'h002,
    ST_ACT_WR = 11'h004,
    ST_READ   = 11'h008,
    ST_WRITE  = 11'h010,
    ST_AREF   = 11'h020,
    ST_MODE   = 11'h040,
    ST_PDOWN  = 11'h080,
    ST_PDEXIT = 11'h100,
    ST_SELF   = 11'h200,
    ST_SREXIT = 11'h400
  } state_t;

endpackage

// file: core/sync_stage.sv
`timescale 1ns/10ps
module sync_stage #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sync_t;

  sync_t s_reg;
  sync_t s_next;

  // first stage feeds only the second
  always_comb begin
    s_next.meta = din;
    s_next.held = s_reg.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.held;

endmodule // sync_stage

// file: core/fc_dram_device.sv
// Function
// - commands ignored until power-down exit delay
// - strobe invalid for mode set cycle time after an extended mode set that changes strobe-free
// - low inside entry window enters self-refresh
// - late fall: refresh then power-down
// - middle fall: either mode, unguaranteed; this model always enters self-refresh
// - strobe invalid until DLL relocks
`timescale 1ns/10ps
module fc_dram_device
  import fc_dram_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic linkClk,
  input wire logic cmdSelN,
  input wire logic cmdFunc,
  input wire logic [1:0] bankIn,
  input wire logic [13:0] addrIn,
  input wire logic power_down_n,
  output logic read_strobe_out,
  output logic readStrobeValid,
  output logic readDataActive,
  output logic statPowerDown,
  output logic statSelfRefresh,
  output logic statDllLocked,
  output logic cmdErrorPulse
);

  localparam int PdaD = 3;
  localparam int RscD = 4;
  localparam int RefcD = 19;

  // ----------------------------------------------------------------
  // link-domain reset
  // ----------------------------------------------------------------
  logic linkRst;
  logic linkRunSync;

  // reset takes hold on the next link edge, its release passes both stages
  sync_stage #(.W(1)) u_rst_sync (
    .clk(linkClk),
    .rst(sys_rst),
    .din(!sys_rst),
    .dout(linkRunSync)
  );

  assign linkRst = !linkRunSync;

  // ----------------------------------------------------------------
  // link-domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    state_t st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] lockCnt;
    logic dllLocked;
    logic [CW-1:0] badCnt;
    logic strobeFree;
    logic [2:0] latency;
    logic burst4;
    logic pdSeen;
    logic strobeLvl;
    logic rdAct;
    logic errTgl;
  } link_t;

  link_t l_reg;
  link_t l_next;
  logic selN;
  logic [CW-1:0] halfBurst;
  logic [CW-1:0] rdEnd;
  logic [CW-1:0] wrEnd;
  logic emrsChange;

  assign selN = cmdSelN;
  assign halfBurst = l_reg.burst4 ? 8'h02 : 8'h01;
  assign rdEnd = 8'(l_reg.latency) + halfBurst - 8'h01;
  assign wrEnd = 8'(l_reg.latency) + halfBurst - 8'h02;
  assign emrsChange = (l_reg.st == ST_ACT_RD) && !selN && (cmdFunc == FN_SECOND_ALT)
                      && (bankIn == BANK_EXTENDED)
                      && (addrIn[STROBE_FREE_BIT] != l_reg.strobeFree);

  always_comb begin
    l_next = l_reg;
    l_next.rdAct = 1'h0;
    if (l_reg.badCnt != '0) begin
      l_next.badCnt = l_reg.badCnt - 8'h01;
    end
    if (l_reg.lockCnt != '0) begin
      l_next.lockCnt = l_reg.lockCnt - 8'h01;
      l_next.dllLocked = (l_reg.lockCnt == 8'h01);
    end
    case (l_reg.st)
      ST_IDLE: begin
        if (!power_down_n) begin
          l_next.st = ST_PDOWN;
        end else if (!selN) begin
          l_next.st = (cmdFunc == FN_FIRST_RD) ? ST_ACT_RD : ST_ACT_WR;
        end
      end
      ST_ACT_RD: begin
        l_next.cnt = '0;
        // a missing second command drops the pair and is flagged
        if (selN) begin
          l_next.st = ST_IDLE;
          l_next.errTgl = !l_reg.errTgl;
        end else if (cmdFunc == FN_SECOND_LAL) begin
          l_next.st = ST_READ;
        end else begin
          l_next.st = ST_MODE;
          l_next.cnt = MODE_SET_CYCLE_TIME - 8'h01;
          if (bankIn == BANK_REGULAR) begin
            l_next.latency = addrIn[LAT_MSB:LAT_LSB];
            l_next.burst4 = addrIn[BURST_BIT];
          end else begin
            l_next.strobeFree = addrIn[STROBE_FREE_BIT];
            if (emrsChange) begin
              l_next.badCnt = MODE_SET_CYCLE_TIME;
            end
            if (addrIn[DLL_OFF_BIT]) begin
              l_next.dllLocked = 1'h0;
              l_next.lockCnt = '0;
            end else if (!l_reg.dllLocked && l_reg.lockCnt == '0) begin
              l_next.lockCnt = DLL_SETTLE_TIME;
            end
          end
        end
      end
      ST_ACT_WR: begin
        l_next.cnt = '0;
        l_next.pdSeen = 1'h0;
        if (selN) begin
          l_next.st = ST_IDLE;
          l_next.errTgl = !l_reg.errTgl;
        end else begin
          l_next.st = (cmdFunc == FN_SECOND_LAL) ? ST_WRITE : ST_AREF;
        end
      end
      ST_READ: begin
        l_next.cnt = l_reg.cnt + 8'h01;
        l_next.rdAct = (l_reg.cnt >= 8'(l_reg.latency));
        if (l_reg.cnt == rdEnd) begin
          l_next.st = ST_IDLE;
        end
      end
      ST_WRITE: begin
        l_next.cnt = l_reg.cnt + 8'h01;
        if (l_reg.cnt == wrEnd) begin
          l_next.st = ST_IDLE;
        end
      end
      ST_AREF: begin
        l_next.cnt = l_reg.cnt + 8'h01;
        // a fall from the window minimum up to the decision limit is always taken as self-refresh
        if (!power_down_n && !l_reg.pdSeen) begin
          l_next.pdSeen = 1'h1;
          if (l_reg.cnt >= SELFREF_ENTRY_WINDOW_MIN
              && l_reg.cnt <= POWERDOWN_DECISION_LIMIT) begin
            l_next.st = ST_SELF;
            l_next.dllLocked = 1'h0;
            l_next.lockCnt = '0;
          end
        end
        if (l_next.st == ST_AREF && l_reg.cnt == RECHARGE_CYCLE_TIME - 8'h01) begin
          l_next.st = l_next.pdSeen ? ST_PDOWN : ST_IDLE;
        end
      end
      ST_MODE: begin
        l_next.cnt = l_reg.cnt - 8'h01;
        if (l_reg.cnt == '0) begin
          l_next.st = ST_IDLE;
        end
      end
      ST_PDOWN: begin
        if (power_down_n) begin
          l_next.st = ST_PDEXIT;
          l_next.cnt = POWER_DOWN_EXIT_TO_COMMAND - 8'h01;
        end
      end
      ST_PDEXIT: begin
        // command pins are ignored until the exit delay has run out
        l_next.cnt = l_reg.cnt - 8'h01;
        if (l_reg.cnt == '0) begin
          l_next.st = ST_IDLE;
        end
      end
      ST_SELF: begin
        if (power_down_n) begin
          l_next.st = ST_SREXIT;
          l_next.cnt = RECHARGE_CYCLE_TIME - 8'h01;
          l_next.lockCnt = DLL_SETTLE_TIME;
        end
      end
      ST_SREXIT: begin
        l_next.cnt = l_reg.cnt - 8'h01;
        if (l_reg.cnt == '0) begin
          l_next.st = ST_IDLE;
        end
      end
      default: begin
        l_next.st = ST_IDLE;
      end
    endcase
    if (l_reg.st == ST_SELF) begin
      l_next.strobeLvl = 1'h0;
    end else if (l_reg.strobeFree || l_next.rdAct) begin
      l_next.strobeLvl = !l_reg.strobeLvl;
    end else begin
      l_next.strobeLvl = 1'h0;
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      l_reg.st <= ST_IDLE;
      l_reg.cnt <= '0;
      l_reg.lockCnt <= DLL_SETTLE_TIME;
      l_reg.dllLocked <= 1'h0;
      l_reg.badCnt <= '0;
      l_reg.strobeFree <= STROBE_FREE_RESET;
      l_reg.latency <= LAT_RESET;
      l_reg.burst4 <= BURST4_RESET;
      l_reg.pdSeen <= 1'h0;
      l_reg.strobeLvl <= 1'h0;
      l_reg.rdAct <= 1'h0;
      l_reg.errTgl <= 1'h0;
    end else begin
      l_reg <= l_next;
    end
  end

  assign read_strobe_out = l_reg.strobeLvl;
  assign readDataActive = l_reg.rdAct;
  assign readStrobeValid = l_reg.dllLocked && (l_reg.badCnt == '0)
                           && (l_reg.st != ST_SELF);

  // ----------------------------------------------------------------
  // status crossing into the system clock
  // ----------------------------------------------------------------
  // the link clock may stop in self-refresh, so only levels and a toggle cross
  logic [3:0] statSync;

  sync_stage #(.W(4)) u_stat_sync (
    .clk(clk_sys),
    .rst(sys_rst),
    .din({l_reg.errTgl, l_reg.dllLocked, l_reg.st == ST_SELF, l_reg.st == ST_PDOWN}),
    .dout(statSync)
  );

  typedef struct packed {
    logic errSeen;
    logic errPulse;
    logic [2:0] stat;
  } sys_t;

  sys_t s_reg;
  sys_t s_next;

  always_comb begin
    s_next.errSeen = statSync[3];
    s_next.errPulse = statSync[3] ^ s_reg.errSeen;
    s_next.stat = statSync[2:0];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign statPowerDown = s_reg.stat[0];
  assign statSelfRefresh = s_reg.stat[1];
  assign statDllLocked = s_reg.stat[2];
  assign cmdErrorPulse = s_reg.errPulse;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (linkRst);

  a_pdexit_delay: assert property ((l_reg.st == ST_PDOWN && power_down_n)
    |-> ##(PdaD + 1) l_reg.st == ST_IDLE) else $error("power-down exit delay wrong");
  a_pdexit_ignore: assert property ((l_reg.st == ST_PDEXIT)
    |=> (l_reg.st == ST_PDEXIT || l_reg.st == ST_IDLE)) else $error("command taken in exit");
  a_extended_mode_set_cmd_strobe: assert property (emrsChange
    |-> ##1 (!readStrobeValid) ##(RscD - 1) !readStrobeValid)
    else $error("strobe valid during mode set time");
  a_sr_window: assert property ((l_reg.st == ST_AREF && !power_down_n && !l_reg.pdSeen
    && l_reg.cnt >= SELFREF_ENTRY_WINDOW_MIN && l_reg.cnt <= SELFREF_ENTRY_WINDOW_MAX)
    |=> l_reg.st == ST_SELF) else $error("window fall missed self-refresh");
  a_late_pdown: assert property ((l_reg.st == ST_AREF && !power_down_n && !l_reg.pdSeen
    && l_reg.cnt > POWERDOWN_DECISION_LIMIT)
    |-> ##[1:RefcD] l_reg.st == ST_PDOWN) else $error("late fall missed power-down");
  a_mid_choice: assert property ((l_reg.st == ST_AREF && !power_down_n && !l_reg.pdSeen
    && l_reg.cnt > SELFREF_ENTRY_WINDOW_MAX && l_reg.cnt <= POWERDOWN_DECISION_LIMIT)
    |=> (l_reg.st == ST_SELF || l_reg.st == ST_AREF)) else $error("middle fall bad state");
  a_relock_strobe: assert property ((l_reg.st == ST_SELF && power_down_n)
    |-> ##1 (!readStrobeValid) [*8]) else $error("strobe valid before relock");

  c_read_burst: cover property (l_reg.st == ST_READ ##1 l_reg.rdAct);
  c_self_entry: cover property (l_reg.st == ST_AREF ##1 l_reg.st == ST_SELF);
  c_pd_exit: cover property (l_reg.st == ST_PDEXIT ##1 l_reg.st == ST_IDLE);

endmodule // fc_dram_device

// file: tb/fc_dram_ctrl_model.sv
`timescale 1ns/10ps
module fc_dram_ctrl_model (
  output logic linkClk,
  output logic cmdSelN,
  output logic cmdFunc,
  output logic [1:0] bankIn,
  output logic [13:0] addrIn,
  output logic power_down_n
);
  initial begin
    linkClk = 1'h0;
    cmdSelN = 1'h1;
    cmdFunc = 1'h0;
    bankIn = 2'h0;
    addrIn = 14'h0000;
    power_down_n = 1'h1;
  end

  // memory clock runs free, also in power-down and self-refresh
  always #7.5 linkClk = ~linkClk;

  // ----
  // command pair: second command on the very next edge
  // ----
  task pair(input logic f1, input logic f2, input logic [1:0] b, input logic [13:0] a);
    @(posedge linkClk);
    #1;
    cmdSelN = 1'h0;
    cmdFunc = f1;
    bankIn = b;
    addrIn = a;
    @(posedge linkClk);
    #1;
    cmdFunc = f2;
    @(posedge linkClk);
    #1;
    // deselected lines must not keep the last value, or a stale match could pass
    cmdSelN = 1'h1;
    cmdFunc = ~f2;
    bankIn = ~b;
    addrIn = ~a;
  endtask

  task drop(input logic f1);
    @(posedge linkClk);
    #1;
    cmdSelN = 1'h0;
    cmdFunc = f1;
    @(posedge linkClk);
    #1;
    cmdSelN = 1'h1;
    cmdFunc = ~f1;
  endtask

  // callers lower the pin in idle or during refresh, never in mid-burst
  task set_pd(input logic v);
    @(posedge linkClk);
    #1;
    power_down_n = v;
  endtask
endmodule // fc_dram_ctrl_model

// file: tb/fc_dram_device_tb.sv
`timescale 1ns/10ps
module fc_dram_device_tb;
  import fc_dram_pkg::*;
  logic clk_sys;
  logic sys_rst;
  logic linkClk, cmdSelN, cmdFunc, power_down_n;
  logic [1:0] bankIn;
  logic [13:0] addrIn;
  logic read_strobe_out, readStrobeValid, readDataActive;
  logic statPowerDown, statSelfRefresh, statDllLocked, cmdErrorPulse;
  logic seen, s;
  int error_cnt, checks, cyc;

  initial clk_sys = 1'h0;
  always #12.5 clk_sys = ~clk_sys;

  fc_dram_ctrl_model i_ctrl (.linkClk(linkClk), .cmdSelN(cmdSelN), .cmdFunc(cmdFunc),
    .bankIn(bankIn), .addrIn(addrIn), .power_down_n(power_down_n));
  fc_dram_device i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .linkClk(linkClk),
    .cmdSelN(cmdSelN), .cmdFunc(cmdFunc), .bankIn(bankIn), .addrIn(addrIn),
    .power_down_n(power_down_n), .read_strobe_out(read_strobe_out),
    .readStrobeValid(readStrobeValid), .readDataActive(readDataActive),
    .statPowerDown(statPowerDown), .statSelfRefresh(statSelfRefresh),
    .statDllLocked(statDllLocked), .cmdErrorPulse(cmdErrorPulse));

  // ----
  // checking and reporting
  // ----
  task finish_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk_bit(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  task chk_cnt(input int got, input int exp, input string msg);
    checks++;
    if (got != exp) begin
      error_cnt++;
      $display("mismatch %0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  task lk(input int n);
    repeat (n) @(posedge linkClk);
    #1;
  endtask

  // data is seen latency+1 edges after the latch edge and lasts burst/2 cycles
  task rd_check(input int lat, input int half);
    int n;
    int w;
    i_ctrl.pair(FN_FIRST_RD, FN_SECOND_LAL, 2'h2, 14'h0003);
    n = 0;
    w = 0;
    while (readDataActive !== 1'h1 && n < 30) begin
      lk(1);
      n++;
    end
    while (readDataActive === 1'h1 && w < 30) begin
      lk(1);
      w++;
    end
    chk_cnt(n, lat + 1, "read start");
    chk_cnt(w, half, "read width");
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("mismatch %0t timeout", $time);
      finish_test;
    end
  end

  // ----
  // main sequence
  // ----
  initial begin
    sys_rst = 1'h1;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk_sys);
    #1;
    sys_rst = 1'h0;
    lk(6);
    chk_bit(readStrobeValid, 1'h0, "valid before lock");
    i_ctrl.pair(FN_FIRST_RD, FN_SECOND_ALT, BANK_EXTENDED, 14'h0000);
    lk(40);
    chk_bit(readStrobeValid, 1'h1, "valid after lock");
    chk_bit(statDllLocked, 1'h1, "lock status");
    rd_check(4, 2);
    lk(2);
    i_ctrl.pair(FN_FIRST_RD, FN_SECOND_ALT, BANK_REGULAR, 14'h0050);
    lk(6);
    rd_check(5, 1);
    lk(2);
    i_ctrl.pair(FN_FIRST_RD, FN_SECOND_ALT, BANK_EXTENDED, 14'h0020);
    lk(1);
    chk_bit(readStrobeValid, 1'h0, "strobe change invalid");
    lk(6);
    chk_bit(readStrobeValid, 1'h1, "strobe change over");
    s = read_strobe_out;
    lk(1);
    chk_bit(read_strobe_out, ~s, "free strobe");
    i_ctrl.drop(FN_FIRST_WR);
    seen = 1'h0;
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      if (cmdErrorPulse === 1'h1) seen = 1'h1;
    end
    chk_bit(seen, 1'h1, "dropped pair");
    i_ctrl.set_pd(1'h0);
    lk(8);
    chk_bit(statPowerDown, 1'h1, "power-down entry");
    i_ctrl.set_pd(1'h1);
    lk(8);
    chk_bit(statPowerDown, 1'h0, "power-down exit");
    rd_check(5, 1);
    lk(2);
    // write burst: power-down only after write latency plus two
    i_ctrl.pair(FN_FIRST_WR, FN_SECOND_LAL, 2'h1, 14'h0005);
    lk(5);
    i_ctrl.set_pd(1'h0);
    lk(8);
    chk_bit(statPowerDown, 1'h1, "power-down after write");
    i_ctrl.set_pd(1'h1);
    lk(8);
    chk_bit(statPowerDown, 1'h0, "power-down exit after write");
    i_ctrl.pair(FN_FIRST_RD, FN_SECOND_ALT, BANK_REGULAR, 14'h0050);
    lk(6);
    // fall inside the entry window: self-refresh
    i_ctrl.pair(FN_FIRST_WR, FN_SECOND_ALT, 2'h0, 14'h0000);
    lk(1);
    i_ctrl.set_pd(1'h0);
    lk(10);
    chk_bit(statSelfRefresh, 1'h1, "self-refresh entry");
    chk_bit(readStrobeValid, 1'h0, "strobe in self-refresh");
    i_ctrl.set_pd(1'h1);
    lk(22);
    chk_bit(statSelfRefresh, 1'h0, "self-refresh exit");
    chk_bit(readStrobeValid, 1'h0, "relock pending");
    lk(40);
    chk_bit(readStrobeValid, 1'h1, "relocked");
    i_ctrl.pair(FN_FIRST_WR, FN_SECOND_ALT, 2'h0, 14'h0000);
    lk(22);
    rd_check(5, 1);
    lk(2);
    // late fall, past the decision limit: refresh then power-down
    i_ctrl.pair(FN_FIRST_WR, FN_SECOND_ALT, 2'h0, 14'h0000);
    lk(9);
    i_ctrl.set_pd(1'h0);
    lk(30);
    chk_bit(statPowerDown, 1'h1, "late fall power-down");
    chk_bit(statSelfRefresh, 1'h0, "late fall no self");
    i_ctrl.set_pd(1'h1);
    lk(8);
    // fall between window and decision limit: either mode is legal
    i_ctrl.pair(FN_FIRST_WR, FN_SECOND_ALT, 2'h0, 14'h0000);
    lk(3);
    i_ctrl.set_pd(1'h0);
    lk(30);
    chk_bit(statSelfRefresh | statPowerDown, 1'h1, "middle fall mode");
    i_ctrl.set_pd(1'h1);
    lk(22);
    chk_bit(statSelfRefresh | statPowerDown, 1'h0, "middle fall exit");
    finish_test;
  end
endmodule // fc_dram_device_tb
